//--- inc/fqh_consts.svh
// constants for the flash query host controller
// Overview of operation
// - address and data on separate parallel lines, never multiplexed
// - host drives chip select low for every transfer
// - write strobe low moves data host to device, output enable low device to host
// - word address width 26, 25, 24 or 23 bits by density
`ifndef FQH_CONSTS_SVH
`define FQH_CONSTS_SVH

`define FQH_ADDR_W         26
`define FQH_DATA_W         16

// apb register offsets
`define FQH_REG_CTRL       12'h000
`define FQH_REG_ADDR       12'h004
`define FQH_REG_WDATA      12'h008
`define FQH_REG_RDATA      12'h00C
`define FQH_REG_STATUS     12'h010
`define FQH_REG_CFG        12'h014

// control fields (write one to start)
`define FQH_CTRL_GO_BIT    0
`define FQH_CTRL_WR_BIT    1
`define FQH_CTRL_RST_BIT   2
// status fields
`define FQH_ST_BUSY_BIT    0
`define FQH_ST_DONE_BIT    1
`define FQH_ST_WP_BIT      2
// config fields
`define FQH_CFG_WP_BIT     0
`define FQH_CFG_DEN_LSB    1
`define FQH_CFG_RESET      3'h0

// query table word offsets and expected values
`define FQH_Q_ACC_MAX      8'h4E
`define FQH_Q_WP_LAYOUT    8'h4F
`define FQH_Q_PGM_SUSP     8'h50
`define FQH_Q_UNLOCK_SKIP  8'h51
`define FQH_Q_OTP_EXP      8'h52
`define FQH_Q_FEATURES     8'h53
`define FQH_Q_PAGE_EXP     8'h54
`define FQH_Q_ERS_SUSP_TO  8'h55
`define FQH_Q_PGM_SUSP_TO  8'h56
`define FQH_Q_PIN_RST_TO   8'h78
`define FQH_Q_POR_TO       8'h79
`define FQH_V_ACC_MAX      16'h0000
`define FQH_V_WP_BOTTOM    16'h0004
`define FQH_V_WP_TOP       16'h0005
`define FQH_V_PGM_SUSP     16'h0001
`define FQH_V_UNLOCK_SKIP  16'h0000
`define FQH_V_OTP_EXP      16'h0009
`define FQH_V_FEATURES     16'h008F
`define FQH_V_PAGE_EXP     16'h0005
`define FQH_V_ERS_SUSP_TO  16'h0006
`define FQH_V_PGM_SUSP_TO  16'h0006
`define FQH_V_PIN_RST_TO   16'h0006
`define FQH_V_POR_TO       16'h0009

// timing: 40 MHz clock
`define FQH_CLK_NS         25
`define FQH_STROBE_NS      100
`define FQH_STROBE_CYC     ((`FQH_STROBE_NS + `FQH_CLK_NS - 1) / `FQH_CLK_NS)
// pin reset wait of 2^6 us
`define FQH_PIN_RST_US     64
`define FQH_PIN_RST_CYC    (`FQH_PIN_RST_US * 1000 / `FQH_CLK_NS)

`endif

//--- inc/fqh_pkg.sv
// types for the flash query host controller
package fqh_pkg;
  typedef enum logic [2:0] {
    FQH_IDLE   = 3'b000,
    FQH_SETUP  = 3'b001,
    FQH_STROBE = 3'b010,
    FQH_HOLD   = 3'b011,
    FQH_RESET  = 3'b100,
    FQH_RWAIT  = 3'b101
  } fqh_state_t;

  typedef enum logic [1:0] {
    FQH_DEN_128M = 2'b00,
    FQH_DEN_256M = 2'b01,
    FQH_DEN_512M = 2'b10,
    FQH_DEN_1G   = 2'b11
  } fqh_density_t;
endpackage

//--- src/fqh_host.sv
// apb-controlled host for a parallel asynchronous nor flash
`timescale 1ns/100ps
`include "fqh_consts.svh"
module fqh_host #(
  parameter int RST_WAIT_CYC = `FQH_PIN_RST_CYC
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [`FQH_ADDR_W-1:0]       word_addr_lines,
  output logic                         chip_sel_n,
  output logic                         out_en_n,
  output logic                         write_n,
  output logic                         flash_reset_n,
  output logic                         write_protect_n,
  input  wire logic [`FQH_DATA_W-1:0]  data_lines_i,
  output logic [`FQH_DATA_W-1:0]       data_lines_o,
  output logic                         data_lines_oe
);
  import fqh_pkg::*;

  localparam logic [7:0] STROBE_CYC = 8'(`FQH_STROBE_CYC);

  fqh_state_t            state;
  fqh_state_t            next_state;
  logic [31:0]           cnt;
  logic [31:0]           next_cnt;
  logic [`FQH_ADDR_W-1:0] addr_reg;
  logic [`FQH_ADDR_W-1:0] next_addr_reg;
  logic [15:0]           wdata;
  logic [15:0]           next_wdata;
  logic [15:0]           rdata;
  logic [15:0]           next_rdata;
  logic                  is_wr;
  logic                  next_is_wr;
  logic                  done;
  logic                  next_done;
  logic [2:0]            cfg;
  logic [2:0]            next_cfg;
  logic [15:0]           din_sync;
  logic                  wr_acc;
  logic                  busy;
  logic [31:0]           next_prdata;

  ////////////////////////////////////////////////////////////////////////
  // address width by density
  function automatic logic [`FQH_ADDR_W-1:0] fqh_mask_addr(
    input logic [`FQH_ADDR_W-1:0] a,
    input fqh_density_t           d
  );
    logic [`FQH_ADDR_W-1:0] m;
    case (d)
      FQH_DEN_128M: m = {3'b000, {23{1'b1}}};
      FQH_DEN_256M: m = {2'b00, {24{1'b1}}};
      FQH_DEN_512M: m = {1'b0, {25{1'b1}}};
      default:      m = {26{1'b1}};
    endcase
    return a & m;
  endfunction

  fqh_sync #(
    .W (16)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (data_lines_i),
    .dout    (din_sync)
  );

  assign busy    = (state != FQH_IDLE);
  assign wr_acc  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // register file and bus sequencer
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_addr_reg = addr_reg;
    next_wdata    = wdata;
    next_rdata    = rdata;
    next_is_wr    = is_wr;
    next_done     = done;
    next_cfg      = cfg;
    if (wr_acc && paddr == `FQH_REG_ADDR && !busy) begin
      next_addr_reg = pwdata[`FQH_ADDR_W-1:0];
    end
    if (wr_acc && paddr == `FQH_REG_WDATA && !busy) begin
      next_wdata = pwdata[15:0];
    end
    // density and protect stay put while a transfer holds the pins
    if (wr_acc && paddr == `FQH_REG_CFG && !busy) begin
      next_cfg = pwdata[2:0];
    end
    if (wr_acc && paddr == `FQH_REG_STATUS && pwdata[`FQH_ST_DONE_BIT]) begin
      next_done = 1'b0;
    end
    case (state)
      FQH_IDLE: begin
        if (wr_acc && paddr == `FQH_REG_CTRL) begin
          if (pwdata[`FQH_CTRL_RST_BIT]) begin
            next_state = FQH_RESET;
            next_cnt   = 32'(STROBE_CYC);
            next_done  = 1'b0;
          end else if (pwdata[`FQH_CTRL_GO_BIT]) begin
            next_is_wr = pwdata[`FQH_CTRL_WR_BIT];
            next_state = FQH_SETUP;
            next_done  = 1'b0;
          end
        end
      end
      FQH_SETUP: begin
        next_state = FQH_STROBE;
        next_cnt   = 32'(STROBE_CYC);
      end
      FQH_STROBE: begin
        // read data sampled four cycles late through the synchroniser
        if (cnt == 32'h0) begin
          next_state = FQH_HOLD;
          next_cnt   = 32'h3;
        end else begin
          next_cnt = cnt - 32'h1;
        end
      end
      FQH_HOLD: begin
        if (cnt == 32'h0) begin
          if (!is_wr) begin
            next_rdata = {8'h00, din_sync[7:0]};
          end
          next_state = FQH_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 32'h1;
        end
      end
      FQH_RESET: begin
        if (cnt == 32'h0) begin
          next_state = FQH_RWAIT;
          next_cnt   = 32'(RST_WAIT_CYC);
        end else begin
          next_cnt = cnt - 32'h1;
        end
      end
      FQH_RWAIT: begin
        if (cnt == 32'h0) begin
          next_state = FQH_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 32'h1;
        end
      end
      default: next_state = FQH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= FQH_IDLE;
      cnt      <= 32'h0;
      addr_reg <= '0;
      wdata    <= 16'h0000;
      rdata    <= 16'h0000;
      is_wr    <= 1'b0;
      done     <= 1'b0;
      cfg      <= `FQH_CFG_RESET;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      addr_reg <= next_addr_reg;
      wdata    <= next_wdata;
      rdata    <= next_rdata;
      is_wr    <= next_is_wr;
      done     <= next_done;
      cfg      <= next_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive, all from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_addr_lines <= '0;
      chip_sel_n      <= 1'b1;
      out_en_n        <= 1'b1;
      write_n         <= 1'b1;
      flash_reset_n   <= 1'b0;
      write_protect_n <= 1'b1;
      data_lines_o    <= 16'h0000;
      data_lines_oe   <= 1'b0;
    end else begin
      word_addr_lines <= fqh_mask_addr(addr_reg,
                           fqh_density_t'(cfg[2:1]));
      chip_sel_n      <= !(next_state == FQH_SETUP ||
                           next_state == FQH_STROBE ||
                           next_state == FQH_HOLD);
      out_en_n        <= !(!next_is_wr && (next_state == FQH_STROBE ||
                           next_state == FQH_HOLD));
      write_n         <= !(next_is_wr && next_state == FQH_STROBE);
      flash_reset_n   <= (next_state != FQH_RESET);
      write_protect_n <= !cfg[`FQH_CFG_WP_BIT];
      data_lines_o    <= wdata;
      data_lines_oe   <= next_is_wr && next_state != FQH_IDLE &&
                         next_state != FQH_RESET &&
                         next_state != FQH_RWAIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read data, captured in the setup cycle so it stands in the access
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      case (paddr)
        `FQH_REG_ADDR:   next_prdata = 32'(addr_reg);
        `FQH_REG_WDATA:  next_prdata = {16'h0000, wdata};
        `FQH_REG_RDATA:  next_prdata = {16'h0000, rdata};
        `FQH_REG_STATUS: next_prdata = {29'h0, !write_protect_n, done, busy};
        `FQH_REG_CFG:    next_prdata = {29'h0, cfg};
        default:         next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end
endmodule

//--- src/fqh_sync.sv
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/100ps
module fqh_sync #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_dout;

  always_comb begin
    next_dout = dout;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_dout[i] = s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule

//--- testbench/fqh_flash_model.sv
// behavioural parallel flash that answers the query words
`timescale 1ns/100ps
module fqh_flash_model #(
  parameter bit TOP = 1'b0
) (
  input  wire logic [25:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic        wp_n,
  input  wire logic [15:0] host_d,
  input  wire logic        host_oe,
  output logic      [15:0] dq,
  output logic      [25:0] wr_addr,
  output logic      [15:0] wr_data,
  output int               wr_count
);
  logic [15:0] q;
  logic [15:0] last = 16'h0000;
  logic        drv;
  always_comb begin
    case (addr[7:0])
      8'h4E: q = 16'h0000;
      8'h4F: q = TOP ? 16'h0005 : 16'h0004;
      8'h50: q = 16'h0001;
      8'h51: q = 16'h0000;
      8'h52: q = 16'h0009;
      8'h53: q = 16'h008F;
      8'h54: q = 16'h0005;
      8'h55, 8'h56, 8'h78: q = 16'h0006;
      8'h79: q = 16'h0009;
      default: q = {8'h00, addr[7:0]};
    endcase
  end
  assign drv = rst_n && !ce_n && !oe_n;
  always @* if (drv) last = q;
  // released lines show the inverse of the last driven word
  assign dq = host_oe ? (drv ? 16'hXXXX : host_d) : (drv ? q : ~last);
  initial wr_count = 0;
  always @(posedge we_n) begin
    if (rst_n && !ce_n && (wp_n || addr >= 26'h0010000)) begin
      wr_addr = addr;
      wr_data = dq;
      wr_count++;
    end
  end
endmodule

//--- testbench/fqh_host_chk.sv
// pin protocol checker for the flash query host
`timescale 1ns/100ps
`include "fqh_consts.svh"
module fqh_host_chk (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic [`FQH_ADDR_W-1:0] word_addr_lines,
  input wire logic                   chip_sel_n,
  input wire logic                   out_en_n,
  input wire logic                   write_n,
  input wire logic                   flash_reset_n,
  input wire logic                   data_lines_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_sel; chip_sel_n |-> out_en_n && write_n && !data_lines_oe;
  endproperty
  a_sel: assert property (p_sel) else $error("strobe unselected");
  property p_fight; !out_en_n |-> !data_lines_oe && write_n; endproperty
  a_fight: assert property (p_fight) else $error("bus fight");
  property p_wdrv; !write_n |-> data_lines_oe; endproperty
  a_wdrv: assert property (p_wdrv) else $error("write undriven");
  property p_wlen; $fell(write_n) |-> !write_n [*4]; endproperty
  a_wlen: assert property (p_wlen) else $error("short write");
  property p_addr; !chip_sel_n && $past(!chip_sel_n) |->
    $stable(word_addr_lines); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_selend; $fell(chip_sel_n) |-> ##[1:30] chip_sel_n; endproperty
  a_selend: assert property (p_selend) else $error("select stuck");
  c_rd: cover property ($fell(out_en_n));
  c_wr: cover property ($fell(write_n));
  c_rst: cover property ($fell(flash_reset_n));
endmodule
bind fqh_host fqh_host_chk u_chk (.pclk, .presetn, .word_addr_lines,
  .chip_sel_n, .out_en_n, .write_n, .flash_reset_n, .data_lines_oe);

//--- testbench/fqh_host_tb.sv
// self-checking bench for the flash query host
`timescale 1ns/100ps
`include "fqh_consts.svh"
module fqh_host_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, chip_sel_n, out_en_n, write_n;
  logic        flash_reset_n, write_protect_n, data_lines_oe;
  logic [25:0] word_addr_lines, wr_addr;
  logic [15:0] data_lines_i, data_lines_o, wr_data;
  int          wr_count, failures = 0, check_count = 0;
  initial forever #12.5 pclk = ~pclk;
  fqh_host #(.RST_WAIT_CYC(20)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .word_addr_lines,
    .chip_sel_n, .out_en_n, .write_n, .flash_reset_n, .write_protect_n,
    .data_lines_i, .data_lines_o, .data_lines_oe);
  fqh_flash_model u_flash (.addr(word_addr_lines), .ce_n(chip_sel_n),
    .oe_n(out_en_n), .we_n(write_n), .rst_n(flash_reset_n),
    .wp_n(write_protect_n), .host_d(data_lines_o), .host_oe(data_lines_oe),
    .dq(data_lines_i), .wr_addr, .wr_data, .wr_count);
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("failures=%0d check_count=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo;
    failures++;
    finish_test;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) tmo;
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask
  task automatic wait_done;
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(`FQH_REG_STATUS, s);
      n++;
      if (n > 100) tmo;
    end while (s[`FQH_ST_DONE_BIT] !== 1'b1);
    wr(`FQH_REG_STATUS, 32'h2);
  endtask
  task automatic op(input logic [31:0] a, input logic [31:0] ctl);
    wr(`FQH_REG_ADDR, a);
    wr(`FQH_REG_CTRL, ctl);
    wait_done;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs;
    logic [31:0] q;
    rd(`FQH_REG_STATUS, q);
    chk(q, 32'h0);
    rd(`FQH_REG_CFG, q);
    chk(q, 32'h0);
    wr(12'h020, 32'hFFFF_FFFF);
    rd(12'h020, q);
    chk(q, 32'h0);
    chk({31'h0, flash_reset_n}, 32'h1);
    chk({31'h0, pslverr}, 32'h0);
  endtask
  task automatic t_query;
    logic [7:0]  off [11] = '{8'h4E, 8'h4F, 8'h50, 8'h51, 8'h52, 8'h53,
                              8'h54, 8'h55, 8'h56, 8'h78, 8'h79};
    logic [15:0] val [11] = '{16'h0, 16'h4, 16'h1, 16'h0, 16'h9, 16'h8F,
                              16'h5, 16'h6, 16'h6, 16'h6, 16'h9};
    logic [31:0] q;
    wr(`FQH_REG_CFG, 32'h6);
    foreach (off[i]) begin
      op({24'h0, off[i]}, 32'h1);
      rd(`FQH_REG_RDATA, q);
      chk(q, {16'h0, val[i]});
    end
  endtask
  task automatic t_busy;
    logic [31:0] q;
    int          n;
    n = wr_count;
    wr(`FQH_REG_ADDR, 32'h53);
    wr(`FQH_REG_CTRL, 32'h1);
    wr(`FQH_REG_ADDR, 32'h54);
    wr(`FQH_REG_CTRL, 32'h3);
    wait_done;
    rd(`FQH_REG_RDATA, q);
    chk(q, 32'h8F);
    chk(wr_count, n);
  endtask
  task automatic t_density;
    for (int d = 0; d < 4; d++) begin
      wr(`FQH_REG_CFG, d << 1);
      wr(`FQH_REG_WDATA, 32'hA5C0 + d);
      op(32'h03FF_FFFF, 32'h3);
      chk({6'h0, wr_addr}, (32'h1 << (23 + d)) - 1);
      chk({16'h0, wr_data}, 32'hA5C0 + d);
    end
  endtask
  task automatic t_wp;
    logic [31:0] q;
    int          n;
    wr(`FQH_REG_CFG, 32'h7);
    rd(`FQH_REG_STATUS, q);
    chk({31'h0, q[`FQH_ST_WP_BIT]}, 32'h1);
    chk({31'h0, write_protect_n}, 32'h0);
    n = wr_count;
    wr(`FQH_REG_WDATA, 32'h1111);
    op(32'h10, 32'h3);
    chk(wr_count, n);
    wr(`FQH_REG_CFG, 32'h6);
    @(posedge pclk);
    chk({31'h0, write_protect_n}, 32'h1);
  endtask
  task automatic t_flash_reset;
    wr(`FQH_REG_CTRL, 32'h4);
    @(posedge pclk);
    chk({31'h0, flash_reset_n}, 32'h0);
    wait_done;
    chk({31'h0, flash_reset_n}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_regs;
    t_query;
    t_busy;
    t_density;
    t_wp;
    t_flash_reset;
    finish_test;
  end
endmodule
